// *** verilog/acc_ctrl.sv ***
// Converter control: start/abort, successive approximation, flag and sleep wake.
// Assumes an external DAC driven by o_dac_code and a comparator on i_cmp_high.
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl (
	// Clock and reset
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_arst_n,
	// Control bits
	input  wire logic                       i_converter_enable,
	input  wire logic                       i_go_set,
	input  wire logic                       i_go_clear,
	input  wire logic [acc_pkg::CHAN_W-1:0] i_channel_select,
	input  wire logic [acc_pkg::CSEL_W-1:0] i_conv_clock_select,
	input  wire logic                       i_flag_clear,
	input  wire logic                       i_conv_done_irq_enable,
	input  wire logic                       i_global_irq_enable,
	input  wire logic                       i_periph_irq_enable,
	input  wire logic                       i_sleep,
	// Analog side
	input  wire logic                       i_rc_clk,
	input  wire logic                       i_cmp_high,
	output logic [acc_pkg::NUM_SRC-1:0]     o_src_onehot,
	output logic                            o_src_valid,
	output logic                            o_ref_fixed_sel,
	output logic [acc_pkg::RES_W-1:0]       o_dac_code,
	output logic                            o_sample,
	// Status
	output logic                            o_go_busy,
	output logic [acc_pkg::RES_W-1:0]       o_conv_result,
	output logic                            o_conv_done_flag,
	output logic                            o_wake,
	output logic                            o_vector_isr
);
	import acc_pkg::*;
	typedef enum {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONV, ST_TAIL} acc_state_t;
	acc_state_t        st_reg, st_next;
	logic [RES_W-1:0]  sar_reg, sar_next, bit_reg, bit_next, res_reg, res_next;
	logic [3:0]        per_reg, per_next;
	logic [1:0]        dly_reg, dly_next;
	logic              flag_reg, flag_next, busy_reg, busy_next;
	logic              cmp_reg;
	logic              tick, is_rc, run_ok, done, abort;
	assign is_rc  = (i_conv_clock_select[1:0] == CSEL_RC_LOW);
	assign run_ok = i_converter_enable && !(i_sleep && !is_rc);
	acc_clkgen u_clk (
		.i_ref_clk (i_ref_clk),
		.i_arst_n  (i_arst_n),
		.i_run     (busy_reg && run_ok),
		.i_sel     (i_conv_clock_select),
		.i_rc_clk  (i_rc_clk),
		.o_tick    (tick)
	);
	// Source routing: one-hot select, reserved codes route nothing
	always_comb begin
		o_src_onehot = '0;
		o_src_valid  = 1'b1;
		if (i_channel_select <= CH_LAST_PIN)
			o_src_onehot[i_channel_select] = 1'b1;
		else if (i_channel_select == CH_TEMP)
			o_src_onehot[NUM_SRC-2] = 1'b1;
		else if (i_channel_select == CH_FVR)
			o_src_onehot[NUM_SRC-1] = 1'b1;
		else
			o_src_valid = 1'b0;
	end
	assign o_ref_fixed_sel = 1'b1;
	assign o_dac_code      = sar_reg | bit_reg;
	assign o_sample        = (st_reg == ST_SAMPLE);
	assign o_go_busy       = busy_reg;
	assign o_conv_result   = res_reg;
	assign o_conv_done_flag = flag_reg;
	assign o_wake          = i_sleep && flag_reg && i_conv_done_irq_enable;
	assign o_vector_isr    = flag_reg && i_conv_done_irq_enable
		&& i_global_irq_enable && i_periph_irq_enable;
	assign abort = busy_reg && (i_go_clear || !run_ok);
	assign done  = (st_reg == ST_TAIL) && tick;
	// Sequencer: delay (RC only), sample period, eight bit trials, tail
	always_comb begin
		st_next   = st_reg;
		sar_next  = sar_reg;
		bit_next  = bit_reg;
		res_next  = res_reg;
		per_next  = per_reg;
		dly_next  = dly_reg;
		busy_next = busy_reg;
		flag_next = flag_reg && !i_flag_clear;
		case (st_reg)
			ST_IDLE: begin
				if (i_go_set && i_converter_enable) begin
					busy_next = 1'b1;
					sar_next  = '0;
					bit_next  = 8'h80;
					per_next  = '0;
					dly_next  = '0;
					st_next   = is_rc ? ST_DELAY : ST_SAMPLE;
				end
			end
			ST_DELAY: begin
				dly_next = dly_reg + 2'h1;
				if (dly_reg == 2'(INSTR_CYC - 1))
					st_next = ST_SAMPLE;
			end
			ST_SAMPLE: if (tick) begin
				per_next = per_reg + 4'h1;
				st_next  = ST_CONV;
			end
			ST_CONV: if (tick) begin
				per_next = per_reg + 4'h1;
				if (!cmp_reg)
					sar_next = sar_reg | bit_reg;
				bit_next = bit_reg >> 1;
				if (bit_reg == 8'h01)
					st_next = ST_TAIL;
			end
			ST_TAIL: if (tick) begin
				per_next = per_reg + 4'h1;
				res_next  = sar_reg;
				flag_next = 1'b1;
				busy_next = 1'b0;
				st_next   = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
		if (abort && !done) begin
			// Unresolved bits copy the last converted bit, the one just above bit_reg
			res_next  = sar_reg | ((({bit_reg[RES_W-2:0], 1'b0} & sar_reg) != 8'h00)
				? (bit_reg | (bit_reg - 8'h01)) : 8'h00);
			busy_next = 1'b0;
			st_next   = ST_IDLE;
		end
	end
	// State registers; the comparator answers our own registered trial code, so it is
	// timed by this clock and one capture flop suffices: a second one would make the
	// divide-by-two bit period shorter than the trial loop
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg     <= ST_IDLE;
			sar_reg    <= '0;
			bit_reg    <= '0;
			res_reg    <= RES_RST;
			per_reg    <= '0;
			dly_reg    <= '0;
			flag_reg   <= 1'b0;
			busy_reg   <= 1'b0;
			cmp_reg    <= 1'b0;
		end else begin
			st_reg     <= st_next;
			sar_reg    <= sar_next;
			bit_reg    <= bit_next;
			res_reg    <= res_next;
			per_reg    <= per_next;
			dly_reg    <= dly_next;
			flag_reg   <= flag_next;
			busy_reg   <= busy_next;
			cmp_reg    <= i_cmp_high;
		end
	end
	sequence s_finish;
		done ##1 (!busy_reg && flag_reg);
	endsequence
	a_done_sets_flag: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		done |-> s_finish)
		else $error("completion did not set flag and clear busy");
	a_ten_periods: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		done |-> per_reg == 4'(CONV_PERIODS - 1))
		else $error("conversion length not ten periods");
	a_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(flag_reg && !i_flag_clear) |=> flag_reg)
		else $error("flag cleared by hardware");
	a_flag_always: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(done && !i_conv_done_irq_enable) |=> flag_reg)
		else $error("flag not set with enable low");
	a_start_busy: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(st_reg == ST_IDLE && i_go_set && i_converter_enable) |=> busy_reg)
		else $error("start ignored");
	a_rc_delay: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(st_reg == ST_IDLE && i_go_set && i_converter_enable && is_rc
		&& !i_go_clear [*1]) |=> st_reg == ST_DELAY)
		else $error("rc start skipped delay");
	a_reserved_none: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_channel_select == 4'hc || i_channel_select == 4'hd)
		|-> (o_src_onehot == '0 && !o_src_valid))
		else $error("reserved channel routed");
	a_sleep_abort: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(busy_reg && i_sleep && !is_rc) |=> !busy_reg)
		else $error("conversion kept running in sleep");
endmodule : acc_ctrl
`default_nettype wire

// *** verilog/acc_pkg.sv ***
// Constants for the converter control block: fields, codes and timing.
// Assumes one 25 MHz reference clock and an external comparator/DAC front end.
// Behaviour
// - Successive approximation gives an 8-bit unsigned code into the result register.
// - The reference is only the internal fixed voltage reference; no external pin.
// - Fourteen sources: twelve pins, temperature indicator, fixed reference output.
// - Channel select routes one source to the shared sample-and-hold; reserved codes 1100 and 1101 route none.
// - Conversion clock: system clock divided by 2,4,8,16,32,64, or RC oscillator.
// - Clock codes: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64, x11 RC.
// - One bit period is one conversion clock; a conversion takes ten periods.
// - Divider clocks follow the system clock; only the RC source is independent.
// - Completion flag rises at every conversion end, regardless of its enable.
// - Flag lives in flag register, enable in enable register; only software clears.
// - Conversion continues in sleep only with the RC clock selected.
// - Completion during sleep wakes the device if its interrupt enable is set; next instruction executes first.
// - After wake, branch to service routine if global and peripheral enables set.
// - On completion clear start bit, set done flag, load result.
// - Start bit with enable begins conversion; early clear aborts, storing partial result.
// - Channel codes 0000-1011 pins, 1110 temperature, 1111 fixed reference.
// - With RC clock, wait one extra instruction cycle after start before converting.
package acc_pkg;
	localparam int          RES_W       = 8;
	localparam int          CHAN_W      = 4;
	localparam int          CSEL_W      = 3;
	localparam int          CONV_PERIODS = 10;
	localparam int          DIV_W       = 6;
	localparam logic [3:0]  CH_LAST_PIN = 4'hb;
	localparam logic [3:0]  CH_TEMP     = 4'he;
	localparam logic [3:0]  CH_FVR      = 4'hf;
	localparam int          NUM_SRC     = 14;
	localparam logic [1:0]  CSEL_RC_LOW = 2'h3;
	localparam int          INSTR_CYC   = 4;
	localparam logic [RES_W-1:0] RES_RST = 8'h00;
	// Divide ratio (half period in system clocks minus one) for each clock code
	function automatic logic [DIV_W-1:0] acc_half_div(input logic [CSEL_W-1:0] sel);
		case (sel)
			3'h0:    acc_half_div = 6'h00;
			3'h4:    acc_half_div = 6'h01;
			3'h1:    acc_half_div = 6'h03;
			3'h5:    acc_half_div = 6'h07;
			3'h2:    acc_half_div = 6'h0f;
			3'h6:    acc_half_div = 6'h1f;
			default: acc_half_div = 6'h00;
		endcase
	endfunction : acc_half_div
endpackage : acc_pkg

// *** verilog/acc_clkgen.sv ***
// Conversion clock tick generator: system clock divider or synchronised RC clock.
// Assumes i_rc_clk is asynchronous; it is sampled through two flip-flops.
`timescale 1ns/1ps
`default_nettype none
module acc_clkgen (
	// Clock and reset
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_arst_n,
	// Control
	input  wire logic                       i_run,
	input  wire logic [acc_pkg::CSEL_W-1:0] i_sel,
	input  wire logic                       i_rc_clk,
	// Tick at each bit period boundary
	output logic                            o_tick
);
	import acc_pkg::*;
	logic [DIV_W-1:0]  cnt_reg, cnt_next;
	logic              ph_reg, ph_next;
	logic [CSEL_W-1:0] sel_reg;
	logic [2:0]        rc_reg;
	logic              is_rc;
	assign is_rc = (i_sel[1:0] == CSEL_RC_LOW);
	// Divider counts half periods; a bit period is two half periods
	always_comb begin
		cnt_next = cnt_reg;
		ph_next  = ph_reg;
		o_tick   = 1'b0;
		if (!i_run || (i_sel != sel_reg)) begin
			cnt_next = '0;
			ph_next  = 1'b0;
		end else if (is_rc) begin
			o_tick = rc_reg[1] & ~rc_reg[2];
		end else if (cnt_reg == acc_half_div(i_sel)) begin
			cnt_next = '0;
			ph_next  = ~ph_reg;
			o_tick   = ph_reg;
		end else begin
			cnt_next = cnt_reg + 6'h01;
		end
	end
	// Registers; rc_reg[0] only feeds rc_reg[1]
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_reg <= '0;
			ph_reg  <= 1'b0;
			sel_reg <= '0;
			rc_reg  <= '0;
		end else begin
			cnt_reg <= cnt_next;
			ph_reg  <= ph_next;
			sel_reg <= i_sel;
			rc_reg  <= {rc_reg[1:0], i_rc_clk};
		end
	end
	// Divide by two gives a tick every two system clocks while the run and code hold
	a_div_two_tick: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(o_tick && i_run && i_sel == 3'h0 && sel_reg == 3'h0)
		|=> !o_tick ##1 (o_tick || !i_run || !$past(i_run) || i_sel != sel_reg))
		else $error("divide by two tick spacing wrong");
endmodule : acc_clkgen
`default_nettype wire

// *** verif/acc_analog_model.sv ***
// Analog front end model: a fixed level for each source and an ideal comparator.
// Assumes the converter holds its source select and trial code steady per bit.
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
	// Source select and trial code from the converter
	input  wire logic [13:0] i_src_onehot,
	input  wire logic [7:0]  i_dac_code,
	// Comparator answer to the converter
	output logic             o_cmp_high
);
	logic [7:0] level;
	// Each source has its own level; pins are taken as set to input and analog;
	// with no source routed the input floats high
	always_comb begin
		level = 8'hff;
		for (int k = 0; k < 14; k++) begin
			if (i_src_onehot[k]) begin
				level = {4'(k), ~4'(k)};
			end
		end
	end
	// A trial code above the input is rejected; the answer settles at once, so
	// every divider is treated as meeting the minimum bit time
	assign o_cmp_high = (i_dac_code > level);
endmodule : acc_analog_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the converter control block.
// Assumes the analog model on the far side and a free-running RC clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import acc_pkg::*;
	logic               clk, rst_n, en, go, stop, fclr, ie, global_irq_enable, periph_irq_enable, slp, rc, cmp;
	logic [CHAN_W-1:0]  chan;
	logic [CSEL_W-1:0]  csel;
	logic               valid, fixed, busy, flag, wake, isr, samp;
	logic [NUM_SRC-1:0] onehot;
	logic [RES_W-1:0]   dac, result;
	int                 fails, samples_checked, cycles, dur;
	int                 codes[8] = '{0, 4, 1, 5, 2, 6, 3, 7};
	int                 divs[8] = '{2, 4, 8, 16, 32, 64, 0, 0};

	acc_ctrl u_dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_converter_enable(en),
		.i_go_set(go), .i_go_clear(stop), .i_channel_select(chan),
		.i_conv_clock_select(csel), .i_flag_clear(fclr), .i_conv_done_irq_enable(ie),
		.i_global_irq_enable(global_irq_enable), .i_periph_irq_enable(periph_irq_enable), .i_sleep(slp),
		.i_rc_clk(rc), .i_cmp_high(cmp), .o_src_onehot(onehot), .o_src_valid(valid),
		.o_ref_fixed_sel(fixed), .o_dac_code(dac), .o_sample(samp), .o_go_busy(busy),
		.o_conv_result(result), .o_conv_done_flag(flag), .o_wake(wake),
		.o_vector_isr(isr));
	acc_analog_model u_ana (.i_src_onehot(onehot), .i_dac_code(dac), .o_cmp_high(cmp));

	// Clocks; RC period is unrelated to the reference so the synchroniser is exercised
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		rc = 1'b0;
		forever #113 rc = ~rc;
	end
	// Hang guard, well above the longest expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Select channel and clock, let the input settle, then pulse the start bit
	task automatic kick(input int ch, input int sel);
		@(negedge clk);
		chan = 4'(ch);
		csel = 3'(sel);
		repeat (8) @(negedge clk);
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
	endtask : kick

	// Bounded wait for the busy bit to drop
	task automatic wait_done();
		dur = 1;
		while (busy === 1'b1 && dur < 3000) begin
			@(negedge clk);
			dur++;
		end
		chk(busy, 0);
	endtask : wait_done

	task automatic pulse_fclr();
		fclr = 1'b1;
		@(negedge clk);
		fclr = 1'b0;
		@(negedge clk);
	endtask : pulse_fclr

	// Main sequence
	initial begin
		{en, go, stop, fclr, ie, global_irq_enable, periph_irq_enable, slp, chan, csel} = '0;
		rst_n = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk(busy, 0);
		chk(result, 16'h00);
		chk(flag, 0);
		chk(fixed, 1);
		for (int c = 0; c < 16; c++) begin
			@(negedge clk);
			chan = 4'(c);
			#1;
			chk(onehot, c < 12 ? 16'h1 << c : c > 13 ? 16'h1 << (c - 2) : 16'h0);
			chk(valid, c < 12 || c > 13);
		end
		kick(1, 0);
		chk(busy, 0);
		en = 1'b1;
		foreach (codes[i]) begin
			kick(i, codes[i]);
			chk(samp, divs[i] != 0);
			wait_done();
			chk(result, {4'(i), ~4'(i)});
			chk(flag, 1);
			if (divs[i] != 0) chk(dur >= 10 * divs[i] && dur <= 25 * divs[i], 1);
			repeat (5) @(negedge clk);
			chk(flag, 1);
			pulse_fclr();
			chk(flag, 0);
		end
		// Abort after the fifth tick at divide by two: 0x90 resolved, bit 4 fills the rest
		kick(9, 0);
		repeat (10) @(negedge clk);
		chk(busy, 1);
		stop = 1'b1;
		@(negedge clk);
		stop = 1'b0;
		repeat (4) @(negedge clk);
		chk(busy, 0);
		chk(result, 16'h9f);
		kick(9, 6);
		repeat (20) @(negedge clk);
		slp = 1'b1;
		repeat (10) @(negedge clk);
		chk(busy, 0);
		slp = 1'b0;
		pulse_fclr();
		ie = 1'b1;
		kick(15, 3);
		slp = 1'b1;
		wait_done();
		chk(result, 16'hd2);
		chk(wake, 1);
		{global_irq_enable, periph_irq_enable} = 2'b11;
		#1;
		chk(isr, 1);
		@(negedge clk);
		{global_irq_enable, periph_irq_enable} = 2'b00;
		#1;
		chk(isr, 0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
